// ---- src/pld_params.svh ----
// Constants for the power, reset and security control block
//
// What this block does
// - Power-up reset clears every macrocell register low without any clock edge.
// - Registered outputs are inverted, so they read high right after power-up reset.
// - With power-down enabled, a high sleep control pin puts the device to sleep.
// - Entering sleep latches and holds all outputs and internal logic state.
// - Outputs in high impedance when sleep begins stay high impedance until it ends.
// - While asleep every device pin except the sleep control pin is ignored.
// - Pin keepers stay active throughout sleep so no pin floats.
// - Without power-down enabled the sleep pin is an ordinary array input.
// - Programmer can preload each macrocell register high or low.
// - Once the security fuse is set, verify and preload are refused.
// - A 64-bit, eight-byte user signature stays readable whatever the fuse state.
// - Security fuse acts at once, so it is programmed as the last step.
// - Each keeper holds the pin's last level while nobody drives it.
// - Eight macrocells: registered output, combinatorial I/O, combinatorial output or input.
// - Exactly one of three modes is active: registered, complex or simple.
// - While asleep clock and data transitions are ignored; registers change only through a preload write.
`ifndef PLD_PARAMS_SVH
`define PLD_PARAMS_SVH

// Register indices on the plain register port
`define A_CTRL      4'h0
`define A_MCFG      4'h1
`define A_PRELOAD   4'h2
`define A_FUSE      4'h3
`define A_STATUS    4'h4
`define A_VERIFY    4'h5
`define A_SIG_BASE  4'h8

// Field positions and reset values
`define CTRL_PD_BIT 2
`define MCFG_RST    16'h0000

// Power-up reset timing
`define PR_TYP_NS   600
`define PR_MAX_NS   1000
`define CLK_NS      4
`define PR_CYCLES   ((`PR_MAX_NS + `CLK_NS - 1) / `CLK_NS)

`endif

// ---- src/pld_pkg.sv ----
// Types shared by the power, reset and security control block
package pld_pkg;

  typedef enum logic [1:0] {
    MODE_REG    = 2'h0,
    MODE_CPLX   = 2'h1,
    MODE_SIMPLE = 2'h2
  } mode_t;

  typedef enum logic [1:0] {
    FN_REG_OUT  = 2'h0,
    FN_COMB_IO  = 2'h1,
    FN_COMB_OUT = 2'h2,
    FN_INPUT    = 2'h3
  } mc_fn_t;

  typedef enum logic [1:0] {
    PWR_RESET = 2'h0,
    PWR_RUN   = 2'h1,
    PWR_SLEEP = 2'h3
  } pwr_t;

endpackage

// ---- src/pin_keeper.sv ----
// Weak hold of pin levels when no driver is present
`timescale 1ns/10ps
module pin_keeper #(
  parameter int N = 8
) (
  // Clock and reset
  input  wire logic         i_mclk,
  input  wire logic         i_rst,
  // Pin drivers
  input  wire logic [N-1:0] i_ext_drv,
  input  wire logic [N-1:0] i_ext_lvl,
  input  wire logic [N-1:0] i_own_oe,
  input  wire logic [N-1:0] i_own_out,
  // Resolved level
  output logic      [N-1:0] o_level
);

  typedef struct packed {
    logic [N-1:0] held;
  } keep_st_t;

  keep_st_t cur_ff;
  keep_st_t nxt_st;

  always_comb
  begin
    nxt_st = cur_ff;
    for (int i = 0; i < N; i++)
    begin
      if (i_ext_drv[i])
        nxt_st.held[i] = i_ext_lvl[i];
      else if (i_own_oe[i])
        nxt_st.held[i] = i_own_out[i];
      // Otherwise last level is kept
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
      cur_ff <= '0;
    else
      cur_ff <= nxt_st;
  end

  assign o_level = cur_ff.held;

  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  a_keep_holds: assert property ((i_ext_drv == '0) && (i_own_oe == '0) |=> $stable(o_level))
    else $error("keeper lost an undriven level");

endmodule // pin_keeper

// ---- src/sig_store.sv ----
// Eight-byte user signature storage
`timescale 1ns/10ps
module sig_store #(
  parameter int BYTES = 8
) (
  // Clock and reset
  input  wire logic                     i_mclk,
  input  wire logic                     i_rst,
  // Write side
  input  wire logic                     i_wr,
  input  wire logic                     i_lock,
  input  wire logic [$clog2(BYTES)-1:0] i_idx,
  input  wire logic [7:0]               i_wdata,
  // Read side
  output logic      [7:0]               o_byte
);

  typedef struct packed {
    logic [BYTES-1:0][7:0] mem;
  } sig_st_t;

  sig_st_t cur_ff;
  sig_st_t nxt_st;

  always_comb
  begin
    nxt_st = cur_ff;
    if (i_wr && !i_lock)
      nxt_st.mem[i_idx] = i_wdata;
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
      cur_ff <= '0;
    else
      cur_ff <= nxt_st;
  end

  // Readable regardless of lock
  assign o_byte = cur_ff.mem[i_idx];

  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  a_sig_locked: assert property (i_wr && i_lock |=> $stable(cur_ff.mem))
    else $error("signature changed after fuse");

endmodule // sig_store

// ---- src/pld_power_reset_security_control.sv ----
// Power-up reset, sleep, preload and security control around eight macrocells
`timescale 1ns/10ps
`include "pld_params.svh"
module pld_power_reset_security_control #(
  parameter int NMC = 8
) (
  // Clock and reset
  input  wire logic           i_mclk,
  input  wire logic           i_rst,
  // Register port
  input  wire logic [3:0]     i_addr,
  input  wire logic [31:0]    i_wdata,
  input  wire logic           i_wr,
  input  wire logic           i_rd,
  output logic      [31:0]    o_rdata,
  // Device pins
  input  wire logic           i_dev_clk,
  input  wire logic           i_oe_n,
  input  wire logic           i_sleep_control_pin,
  input  wire logic [NMC-1:0] i_in,
  input  wire logic [NMC-1:0] i_in_drv,
  input  wire logic [NMC-1:0] i_io_lvl,
  input  wire logic [NMC-1:0] i_io_drv,
  output logic      [NMC-1:0] o_io_out,
  output logic      [NMC-1:0] o_io_oe,
  // Array side
  input  wire logic [NMC-1:0] i_sum,
  input  wire logic [NMC-1:0] i_pterm_oe,
  output logic      [2*NMC:0] o_array_in,
  output logic      [NMC-1:0] o_mc_q,
  // Status
  output logic                o_ready,
  output logic                o_sleeping
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    pld_pkg::pwr_t     pwr;
    logic [8:0]        cnt;
    logic              clk_prev;
    logic              fuse;
    pld_pkg::mode_t    mode;
    logic              pd_en;
    logic [2*NMC-1:0]  mcfg;
    logic [NMC-1:0]    q;
    logic [NMC-1:0]    out;
    logic [NMC-1:0]    oe;
    logic [2*NMC:0]    ain;
    logic [31:0]       rdata;
  } ctl_st_t;

  ctl_st_t cur_ff;
  ctl_st_t nxt_st;

  logic [NMC-1:0] io_lvl;
  logic [NMC-1:0] in_lvl;
  logic [7:0]     sig_byte;
  logic           sig_wr;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Returns {oe, out} for one macrocell
  function automatic logic [1:0] mc_drive(
    input pld_pkg::mode_t mode,
    input logic [1:0]     fn,
    input int             idx,
    input logic           q,
    input logic           sum,
    input logic           pt,
    input logic           oe_n
  );
    logic [1:0] r;
    r = 2'h0;
    case (mode)
      pld_pkg::MODE_REG:
      begin
        if (fn == pld_pkg::FN_REG_OUT)
          r = {~oe_n, ~q};
        else if (fn != pld_pkg::FN_INPUT)
          r = {pt, sum};
      end
      pld_pkg::MODE_CPLX:
      begin
        if (fn != pld_pkg::FN_INPUT || idx == 0 || idx == NMC - 1)
          r = {pt, sum};
      end
      default:
      begin
        if (fn != pld_pkg::FN_INPUT || idx == NMC / 2 - 1 || idx == NMC / 2)
          r = {1'b1, sum};
      end
    endcase
    return r;
  endfunction

  function automatic logic is_reg(input pld_pkg::mode_t mode, input logic [1:0] fn);
    return (mode == pld_pkg::MODE_REG) && (fn == pld_pkg::FN_REG_OUT);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    logic       rise;
    logic       go_sleep;
    logic [1:0] drv;
    logic [NMC-1:0] fb;
    rise     = 1'b0;
    go_sleep = 1'b0;
    drv      = 2'h0;
    fb       = '0;
    nxt_st   = cur_ff;
    nxt_st.rdata = '0;

    case (cur_ff.pwr)
      pld_pkg::PWR_RESET:
      begin
        // Registers stay low; pin clock ignored until interval ends
        nxt_st.q        = '0;
        nxt_st.out      = '1;
        nxt_st.clk_prev = 1'b1;
        nxt_st.cnt      = cur_ff.cnt + 9'h001;
        if (cur_ff.cnt == 9'(`PR_CYCLES - 1))
          nxt_st.pwr = pld_pkg::PWR_RUN;
      end
      pld_pkg::PWR_RUN:
      begin
        go_sleep = cur_ff.pd_en && i_sleep_control_pin;
        if (go_sleep)
        begin
          // Hold everything as it stands
          nxt_st.pwr      = pld_pkg::PWR_SLEEP;
          nxt_st.clk_prev = 1'b1;
        end
        else
        begin
          // First rise here relies on met setup times
          rise = i_dev_clk && !cur_ff.clk_prev;
          nxt_st.clk_prev = i_dev_clk;
          for (int i = 0; i < NMC; i++)
          begin
            if (rise && is_reg(cur_ff.mode, cur_ff.mcfg[2*i +: 2]))
              nxt_st.q[i] = i_sum[i];
            drv = mc_drive(cur_ff.mode, cur_ff.mcfg[2*i +: 2], i, cur_ff.q[i],
                           i_sum[i], i_pterm_oe[i], i_oe_n);
            nxt_st.oe[i]  = drv[1];
            nxt_st.out[i] = drv[0];
            fb[i] = is_reg(cur_ff.mode, cur_ff.mcfg[2*i +: 2]) ? cur_ff.q[i] : io_lvl[i];
          end
          // Sleep pin joins the array only without power-down
          nxt_st.ain = {(cur_ff.pd_en ? 1'b0 : i_sleep_control_pin), in_lvl, fb};
        end
      end
      pld_pkg::PWR_SLEEP:
      begin
        // Clock and inputs ignored, pins held
        nxt_st.clk_prev = 1'b1;
        if (!i_sleep_control_pin)
          nxt_st.pwr = pld_pkg::PWR_RUN;
      end
      default:
      begin
        nxt_st.pwr = pld_pkg::PWR_RESET;
      end
    endcase

    // Register writes
    if (i_wr)
    begin
      if (i_addr == `A_CTRL)
      begin
        if (!cur_ff.fuse && i_wdata[1:0] != 2'h3)
          nxt_st.mode = pld_pkg::mode_t'(i_wdata[1:0]);
        if (!cur_ff.fuse)
          nxt_st.pd_en = i_wdata[`CTRL_PD_BIT];
      end
      else if (i_addr == `A_MCFG)
      begin
        if (!cur_ff.fuse)
          nxt_st.mcfg = i_wdata[2*NMC-1:0];
      end
      else if (i_addr == `A_PRELOAD)
      begin
        if (!cur_ff.fuse && cur_ff.pwr != pld_pkg::PWR_RESET)
          nxt_st.q = i_wdata[NMC-1:0];
      end
      else if (i_addr == `A_FUSE)
      begin
        if (i_wdata[0])
          nxt_st.fuse = 1'b1;
      end
    end

    // Register reads, data in the following cycle only
    if (i_rd)
    begin
      if (i_addr == `A_CTRL)
        nxt_st.rdata = {29'h0, cur_ff.pd_en, cur_ff.mode};
      else if (i_addr == `A_MCFG)
        nxt_st.rdata = 32'(cur_ff.mcfg);
      else if (i_addr == `A_FUSE)
        nxt_st.rdata = {31'h0, cur_ff.fuse};
      else if (i_addr == `A_STATUS)
        nxt_st.rdata = 32'({cur_ff.fuse, (cur_ff.pwr == pld_pkg::PWR_SLEEP),
                            (cur_ff.pwr != pld_pkg::PWR_RESET), cur_ff.mode, cur_ff.q});
      else if (i_addr == `A_VERIFY)
      begin
        if (!cur_ff.fuse)
          nxt_st.rdata = {13'h0, cur_ff.pd_en, cur_ff.mode, cur_ff.mcfg};
      end
      else if (i_addr >= `A_SIG_BASE)
        nxt_st.rdata = {24'h0, sig_byte};
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      cur_ff       <= '0;
      cur_ff.pwr   <= pld_pkg::PWR_RESET;
      cur_ff.mode  <= pld_pkg::MODE_REG;
      cur_ff.mcfg  <= `MCFG_RST;
      cur_ff.out   <= '1;
      cur_ff.clk_prev <= 1'b1;
    end
    else
      cur_ff <= nxt_st;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Keepers and signature

  pin_keeper #(.N(NMC)) u_io_keep (
    .i_mclk    (i_mclk),
    .i_rst     (i_rst),
    .i_ext_drv (i_io_drv),
    .i_ext_lvl (i_io_lvl),
    .i_own_oe  (cur_ff.oe),
    .i_own_out (cur_ff.out),
    .o_level   (io_lvl)
  );

  pin_keeper #(.N(NMC)) u_in_keep (
    .i_mclk    (i_mclk),
    .i_rst     (i_rst),
    .i_ext_drv (i_in_drv),
    .i_ext_lvl (i_in),
    .i_own_oe  ('0),
    .i_own_out ('0),
    .o_level   (in_lvl)
  );

  assign sig_wr = i_wr && (i_addr >= `A_SIG_BASE);

  sig_store #(.BYTES(8)) u_sig (
    .i_mclk  (i_mclk),
    .i_rst   (i_rst),
    .i_wr    (sig_wr),
    .i_lock  (cur_ff.fuse),
    .i_idx   (i_addr[2:0]),
    .i_wdata (i_wdata[7:0]),
    .o_byte  (sig_byte)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign o_rdata    = cur_ff.rdata;
  assign o_io_out   = cur_ff.out;
  assign o_io_oe    = cur_ff.oe;
  assign o_array_in = cur_ff.ain;
  assign o_mc_q     = cur_ff.q;
  assign o_ready    = (cur_ff.pwr != pld_pkg::PWR_RESET);
  assign o_sleeping = (cur_ff.pwr == pld_pkg::PWR_SLEEP);

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  a_reset_clears: assert property (!o_ready |-> (o_mc_q == '0) && (o_io_out == '1))
    else $error("registers not cleared during power-up reset");

  a_reset_length: assert property ($rose(o_ready) |-> $past(cur_ff.cnt) == 9'(`PR_CYCLES - 1))
    else $error("power-up reset interval wrong length");

  a_sleep_entry: assert property (o_ready && !o_sleeping && cur_ff.pd_en && i_sleep_control_pin
                                  |=> o_sleeping)
    else $error("sleep not entered");

  a_sleep_hold: assert property (o_sleeping && $past(o_sleeping)
                                 |-> $stable(o_io_out) && $stable(o_array_in))
    else $error("outputs moved while asleep");

  a_hiz_kept: assert property (o_sleeping && $past(o_sleeping) |-> $stable(o_io_oe))
    else $error("output enable changed while asleep");

  a_no_pd: assert property (o_ready && !cur_ff.pd_en && !o_sleeping |=> !o_sleeping)
    else $error("sleep entered without power-down enabled");

  a_sleep_regs: assert property (o_sleeping && !(i_wr && i_addr == `A_PRELOAD) |=> $stable(o_mc_q))
    else $error("register changed while asleep");

  a_preload: assert property (o_ready && !cur_ff.fuse && i_wr && i_addr == `A_PRELOAD
                              |=> o_mc_q == $past(i_wdata[NMC-1:0]))
    else $error("preload not taken");

  a_verify_lock: assert property (cur_ff.fuse && i_rd && i_addr == `A_VERIFY |=> o_rdata == '0)
    else $error("verify data leaked after fuse");

  a_wake: assert property (o_sleeping && !i_sleep_control_pin |=> o_ready && !o_sleeping)
    else $error("no wake when sleep pin low");

  a_reg_outputs: assert property ((cur_ff.pwr == pld_pkg::PWR_RUN) && !(cur_ff.pd_en && i_sleep_control_pin)
                                  && (cur_ff.mode == pld_pkg::MODE_REG) && (cur_ff.mcfg == `MCFG_RST)
                                  |=> o_io_out == ~$past(o_mc_q))
    else $error("registered output not inverted from register");

  a_reg_load: assert property ((cur_ff.pwr == pld_pkg::PWR_RUN) && !cur_ff.pd_en && !i_wr
                               && i_dev_clk && !cur_ff.clk_prev
                               && (cur_ff.mode == pld_pkg::MODE_REG) && (cur_ff.mcfg == `MCFG_RST)
                               |=> o_mc_q == $past(i_sum))
    else $error("registered macrocell missed a clock rise");

  a_pin_to_array: assert property ((cur_ff.pwr == pld_pkg::PWR_RUN) && !cur_ff.pd_en
                                   |=> o_array_in[2*NMC] == $past(i_sleep_control_pin))
    else $error("sleep pin not passed to the array");

  a_pin_masked: assert property ((cur_ff.pwr == pld_pkg::PWR_RUN) && cur_ff.pd_en && !i_sleep_control_pin
                                 |=> !o_array_in[2*NMC])
    else $error("sleep pin reached the array with power-down on");

  a_mode_legal: assert property (cur_ff.mode inside
                                 {pld_pkg::MODE_REG, pld_pkg::MODE_CPLX, pld_pkg::MODE_SIMPLE})
    else $error("configuration mode out of range");

  a_fuse_now: assert property (i_wr && (i_addr == `A_FUSE) && i_wdata[0] |=> cur_ff.fuse)
    else $error("security fuse not set at once");

  a_fuse_sticky: assert property (cur_ff.fuse |=> cur_ff.fuse)
    else $error("security fuse cleared");

  a_preload_locked: assert property (cur_ff.fuse && i_wr && (i_addr == `A_PRELOAD)
                                     && (cur_ff.mode != pld_pkg::MODE_REG) |=> $stable(o_mc_q))
    else $error("preload taken after fuse");

  a_sig_readable: assert property (i_rd && (i_addr >= `A_SIG_BASE)
                                   |=> o_rdata == {24'h0, $past(sig_byte)})
    else $error("signature byte not read back");

endmodule // pld_power_reset_security_control

// ---- sim/sys_pin_model.sv ----
// Model of the system logic that drives the device pins
`timescale 1ns/10ps
module sys_pin_model (
  // Clock and status
  input  wire logic       i_mclk,
  input  wire logic       i_ready,
  // Device pins
  output logic            o_dev_clk,
  output logic [7:0]      o_in,
  output logic [7:0]      o_in_drv,
  output logic [7:0]      o_io_lvl,
  output logic [7:0]      o_io_drv
);
  initial
  begin
    o_dev_clk = 1'b0;
    o_in      = 8'h00;
    o_in_drv  = 8'hFF;
    o_io_lvl  = 8'h00;
    o_io_drv  = 8'h00;
  end

  // Undriven I/O lines wander every cycle
  always @(posedge i_mclk)
    o_io_lvl <= ~o_io_lvl;

  ////////////////////////////////////////////////////////////////////////////
  // One device clock pulse, only once the reset interval is over
  task automatic pulse_clock();
    if (i_ready !== 1'b1)
      return;
    repeat (2) @(posedge i_mclk);
    o_dev_clk <= 1'b1;
    repeat (2) @(posedge i_mclk);
    o_dev_clk <= 1'b0;
    repeat (2) @(posedge i_mclk);
  endtask

  task automatic drive_in(input logic [7:0] lvl);
    o_in     <= lvl;
    o_in_drv <= 8'hFF;
  endtask

  // Released inputs show the inverse level
  task automatic release_in();
    o_in     <= ~o_in;
    o_in_drv <= 8'h00;
  endtask
endmodule // sys_pin_model

// ---- sim/test_pld_power_reset_security_control.sv ----
// Testbench of the power, reset and security control block
`timescale 1ns/10ps
`include "pld_params.svh"
module test_pld_power_reset_security_control;
  logic        i_mclk;
  logic        i_rst;
  logic [3:0]  i_addr;
  logic [31:0] i_wdata;
  logic        i_wr;
  logic        i_rd;
  logic [31:0] o_rdata;
  logic        i_dev_clk;
  logic        i_oe_n;
  logic        i_sleep_control_pin;
  logic [7:0]  i_in;
  logic [7:0]  i_in_drv;
  logic [7:0]  i_io_lvl;
  logic [7:0]  i_io_drv;
  logic [7:0]  o_io_out;
  logic [7:0]  o_io_oe;
  logic [7:0]  i_sum;
  logic [7:0]  i_pterm_oe;
  logic [16:0] o_array_in;
  logic [7:0]  o_mc_q;
  logic        o_ready;
  logic        o_sleeping;
  int          error_cnt;
  int          comparisons;

  pld_power_reset_security_control #(.NMC(8)) i_dut (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_dev_clk(i_dev_clk),
    .i_oe_n(i_oe_n), .i_sleep_control_pin(i_sleep_control_pin), .i_in(i_in),
    .i_in_drv(i_in_drv), .i_io_lvl(i_io_lvl), .i_io_drv(i_io_drv),
    .o_io_out(o_io_out), .o_io_oe(o_io_oe), .i_sum(i_sum), .i_pterm_oe(i_pterm_oe),
    .o_array_in(o_array_in), .o_mc_q(o_mc_q), .o_ready(o_ready), .o_sleeping(o_sleeping));

  sys_pin_model i_sys (
    .i_mclk(i_mclk), .i_ready(o_ready), .o_dev_clk(i_dev_clk), .o_in(i_in),
    .o_in_drv(i_in_drv), .o_io_lvl(i_io_lvl), .o_io_drv(i_io_drv));

  initial
  begin
    i_mclk = 1'b0;
    forever #2 i_mclk = ~i_mclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("mismatches %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic check_val(input string nm, input logic [31:0] exp, got);
    comparisons++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_mclk);
    i_wr <= 1'b0;
    @(posedge i_mclk);
  endtask

  task automatic chk_rd(input string nm, input logic [3:0] a, input logic [31:0] m, e);
    logic [31:0] v;
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1;
    v = o_rdata;
    check_val(nm, e, v & m);
    @(posedge i_mclk);
  endtask

  initial
  begin
    repeat (5000) @(posedge i_mclk);
    error_cnt++;
    results();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    error_cnt = 0;
    comparisons = 0;
    i_rst = 1'b1;
    i_addr = 4'h0;
    i_wdata = 32'h0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_oe_n = 1'b0;
    i_sleep_control_pin = 1'b0;
    i_sum = 8'h00;
    i_pterm_oe = 8'h00;
    repeat (8) @(posedge i_mclk);
    i_rst <= 1'b0;
    #1;
    check_val("q", 32'h0, o_mc_q);
    check_val("io_out", 32'hFF, o_io_out);
    wr(`A_PRELOAD, 32'hA5);
    #1;
    check_val("q", 32'h0, o_mc_q);
    i_sys.pulse_clock();
    wt(`PR_CYCLES - 3);
    check_val("ready", 32'h0, o_ready);
    wt(3);
    check_val("ready", 32'h1, o_ready);
    check_val("q", 32'h0, o_mc_q);
    check_val("io_out", 32'hFF, o_io_out);
    check_val("io_oe", 32'hFF, o_io_oe);
    chk_rd("verify", `A_VERIFY, 32'hFFFFFFFF, 32'h0);
    chk_rd("unmapped", 4'h6, 32'hFFFFFFFF, 32'h0);
    chk_rd("unmapped", 4'h7, 32'hFFFFFFFF, 32'h0);
    // Preload and clocked load
    wr(`A_PRELOAD, 32'hA5);
    #1;
    check_val("q", 32'hA5, o_mc_q);
    wt(1);
    check_val("io_out", 32'h5A, o_io_out);
    wr(`A_PRELOAD, 32'h5A);
    #1;
    check_val("q", 32'h5A, o_mc_q);
    i_sum <= 8'h3C;
    i_sys.pulse_clock();
    wt(1);
    check_val("q", 32'h3C, o_mc_q);
    // Keepers
    i_sys.drive_in(8'hA5);
    wt(3);
    i_sys.release_in();
    wt(3);
    check_val("kept", 32'hA5, o_array_in[15:8]);
    // Sleep pin without power-down
    i_sleep_control_pin <= 1'b1;
    wt(3);
    check_val("sleeping", 32'h0, o_sleeping);
    check_val("pin_in", 32'h1, o_array_in[16]);
    i_sleep_control_pin <= 1'b0;
    wr(`A_CTRL, 32'h4);
    i_oe_n <= 1'b1;
    wt(3);
    check_val("io_oe", 32'h0, o_io_oe);
    // Sleep with power-down
    i_sleep_control_pin <= 1'b1;
    wt(3);
    check_val("sleeping", 32'h1, o_sleeping);
    check_val("pin_in", 32'h0, o_array_in[16]);
    i_oe_n <= 1'b0;
    i_sum <= 8'hFF;
    i_sys.drive_in(8'hC3);
    i_sys.pulse_clock();
    wt(1);
    check_val("q", 32'h3C, o_mc_q);
    check_val("io_oe", 32'h0, o_io_oe);
    check_val("io_out", 32'hC3, o_io_out);
    check_val("kept", 32'hA5, o_array_in[15:8]);
    i_sys.release_in();
    wt(2);
    check_val("kept", 32'hA5, o_array_in[15:8]);
    // Wake
    i_sleep_control_pin <= 1'b0;
    wt(3);
    check_val("sleeping", 32'h0, o_sleeping);
    check_val("q", 32'h3C, o_mc_q);
    check_val("io_oe", 32'hFF, o_io_oe);
    i_sys.pulse_clock();
    wt(1);
    check_val("q", 32'hFF, o_mc_q);
    // Modes and macrocell functions
    for (int m = 0; m < 4; m++)
    begin
      wr(`A_CTRL, 32'(m));
      chk_rd("mode", `A_VERIFY, 32'h30000, (m == 3) ? 32'h20000 : 32'(m << 16));
    end
    wr(`A_MCFG, 32'hE4E4);
    chk_rd("mcfg", `A_VERIFY, 32'hFFFF, 32'hE4E4);
    wt(1);
    check_val("io_oe", 32'h7F, o_io_oe);
    chk_rd("status", `A_STATUS, 32'hFFFFFFFF, 32'h6FF);
    // Signature and security fuse
    for (int i = 0; i < 8; i++)
      wr(4'(`A_SIG_BASE + i), 32'(17 * (i + 1)));
    for (int i = 0; i < 8; i++)
      chk_rd("sig", 4'(`A_SIG_BASE + i), 32'hFF, 32'(17 * (i + 1)));
    wr(`A_FUSE, 32'h1);
    chk_rd("fuse", `A_FUSE, 32'h1, 32'h1);
    chk_rd("status", `A_STATUS, 32'h1000, 32'h1000);
    chk_rd("verify", `A_VERIFY, 32'hFFFFFFFF, 32'h0);
    wr(`A_PRELOAD, 32'h0);
    #1;
    check_val("q", 32'hFF, o_mc_q);
    wr(`A_SIG_BASE, 32'hFF);
    chk_rd("sig", `A_SIG_BASE, 32'hFF, 32'h11);
    results();
  end
endmodule // test_pld_power_reset_security_control
